/* src/pid_reg_pkg.sv */
// Functional notes
// - full feedback swing within derivative time gives full output
// - negative output clamped to reverse cutoff limit
// - inside deviation deadband output holds unchanged
// - derivative contribution clipped to configured clip
// - effective setpoint ramps linearly over change time
// - feedback and output each have first-order filter
// - condition zero always uses gain set one
// - condition one selects set two by terminal
// - condition two interpolates gains between deviation thresholds
// - condition three interpolates gains by output frequency
// - start forces initial output for hold time
// - per-beat output change limited, beat is 2 ms
// - separate step limits for increase and decrease
// - integral separation freezes integral while pause active
// - optional integral stop while output at limit
// - stop option chooses whether stopped drive computes
// - feedback below loss threshold too long raises fault
// - sleep basis one selects pressure-based sleep
// - wake after feedback below wake level for delay
// - sleep when feedback exceeds sleep level
// - run indicator blinks with 1 s period asleep
// - direction zero raises output when feedback low
`default_nettype none
package pid_reg_pkg;
    localparam int AW = 5;
    localparam int DW = 16;
    localparam int NCFG = 25;
    // register indices, address equals index
    localparam logic [AW-1:0] A_CTRL = 5'h00;
    localparam logic [AW-1:0] A_KP1 = 5'h01;
    localparam logic [AW-1:0] A_TI1 = 5'h02;
    localparam logic [AW-1:0] A_TD1 = 5'h03;
    localparam logic [AW-1:0] A_KP2 = 5'h04;
    localparam logic [AW-1:0] A_TI2 = 5'h05;
    localparam logic [AW-1:0] A_TD2 = 5'h06;
    localparam logic [AW-1:0] A_REVCUT = 5'h07;
    localparam logic [AW-1:0] A_DBAND = 5'h08;
    localparam logic [AW-1:0] A_DCLIP = 5'h09;
    localparam logic [AW-1:0] A_RAMP = 5'h0A;
    localparam logic [AW-1:0] A_FBFILT = 5'h0B;
    localparam logic [AW-1:0] A_OUTFILT = 5'h0C;
    localparam logic [AW-1:0] A_SWLO = 5'h0D;
    localparam logic [AW-1:0] A_SWHI = 5'h0E;
    localparam logic [AW-1:0] A_INIT = 5'h0F;
    localparam logic [AW-1:0] A_HOLD = 5'h10;
    localparam logic [AW-1:0] A_FSTEP = 5'h11;
    localparam logic [AW-1:0] A_RSTEP = 5'h12;
    localparam logic [AW-1:0] A_LOSSTHR = 5'h13;
    localparam logic [AW-1:0] A_LOSSTIME = 5'h14;
    localparam logic [AW-1:0] A_WAKEPCT = 5'h15;
    localparam logic [AW-1:0] A_WAKEDLY = 5'h16;
    localparam logic [AW-1:0] A_SLPPCT = 5'h17;
    localparam logic [AW-1:0] A_SLPDLY = 5'h18;
    localparam logic [AW-1:0] A_STATUS = 5'h19;
    localparam logic [AW-1:0] A_OUT = 5'h1A;
    // control register fields, then the status fault bit
    localparam int F_DIR = 0;
    localparam int F_STOPC = 1;
    localparam int F_SLEEP = 2;
    localparam int F_SW = 4;
    localparam int F_ISEP = 8;
    localparam int F_ILIM = 9;
    localparam int F_FAULT = 0;
    // reset values
    localparam logic [DW-1:0] CTRL_RST = 16'h0000;
    localparam logic [DW-1:0] KP_RST = 16'h00C8;
    localparam logic [DW-1:0] TI_RST = 16'h00C8;
    localparam logic [DW-1:0] TD_RST = 16'h0000;
    localparam logic [DW-1:0] ZERO_RST = 16'h0000;
    localparam logic [DW-1:0] DCLIP_RST = 16'h000A;
    localparam logic [DW-1:0] SWLO_RST = 16'h07D0;
    localparam logic [DW-1:0] SWHI_RST = 16'h1F40;
    localparam logic [DW-1:0] STEP_RST = 16'h0064;
    localparam logic [DW-1:0] WAKEPCT_RST = 16'h0320;
    localparam logic [DW-1:0] WAKEDLY_RST = 16'h000A;
    localparam logic [DW-1:0] SLPPCT_RST = 16'h0320;
    localparam logic [DW-1:0] SLPDLY_RST = 16'h0258;
    localparam logic [NCFG-1:0][DW-1:0] CFG_RST = {
        SLPDLY_RST, SLPPCT_RST, WAKEDLY_RST, WAKEPCT_RST, ZERO_RST, ZERO_RST,
        STEP_RST, STEP_RST, ZERO_RST, ZERO_RST, SWHI_RST, SWLO_RST, ZERO_RST,
        ZERO_RST, ZERO_RST, DCLIP_RST, ZERO_RST, ZERO_RST, TD_RST, TI_RST,
        KP_RST, TD_RST, TI_RST, KP_RST, CTRL_RST};
    // scaling and timing
    localparam int FULL = 10000;
    localparam int ALPHA_ONE = 1024;
    localparam int KP_DIV = 1000;
    localparam int PCT_DIV = 1000;
    localparam int CLK_NS = 4;
    localparam int BEAT_NS = 2000000;
    localparam int BEAT_CYC = BEAT_NS / CLK_NS;
    localparam int B_PER_10MS = 10000000 / BEAT_NS;
    localparam int B_PER_100MS = 100000000 / BEAT_NS;
    localparam int BLINK_HALF_NS = 500000000;
    localparam int BLINK_BEATS = BLINK_HALF_NS / BEAT_NS;
    localparam int TD_MS_PER_BEAT = BEAT_NS / 1000000;
endpackage : pid_reg_pkg
`default_nettype wire

/* src/process_pid_regulator.sv */
// Design decisions made here: strobed register access and the register addresses.
`default_nettype none
module process_pid_regulator #(
    parameter int unsigned BEAT_CYCLES = pid_reg_pkg::BEAT_CYC
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rstn,
    input  wire logic [pid_reg_pkg::AW-1:0]  i_addr,
    input  wire logic [pid_reg_pkg::DW-1:0]  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [pid_reg_pkg::DW-1:0]  o_rdata,
    input  wire logic [pid_reg_pkg::DW-1:0]  i_setpoint,
    input  wire logic [pid_reg_pkg::DW-1:0]  i_feedback,
    input  wire logic [pid_reg_pkg::DW-1:0]  i_abs_freq,
    input  wire logic                        i_running,
    input  wire logic                        i_gain_sel,
    input  wire logic                        i_int_pause,
    input  wire logic                        i_at_limit,
    output logic signed [pid_reg_pkg::DW-1:0] o_freq_cmd,
    output logic                             o_beat,
    output logic                             o_loss_fault,
    output logic                             o_asleep,
    output logic                             o_run_led
);
    import pid_reg_pkg::*;

    typedef logic signed [31:0] s32_t;

    typedef struct packed {
        logic [NCFG-1:0][DW-1:0] cfg;
        logic [31:0]             beat_cnt;
        logic                    beat;
        s32_t                    sp;
        s32_t                    fb_f;
        s32_t                    fb_prev;
        s32_t                    iacc;
        s32_t                    raw;
        s32_t                    out_f;
        logic [DW-1:0]           cmd;
        logic [31:0]             hold_cnt;
        logic                    holding;
        logic                    run_prev;
        logic [31:0]             loss_cnt;
        logic                    fault;
        logic [31:0]             slp_cnt;
        logic                    asleep;
        logic [15:0]             blink_cnt;
        logic                    blink;
        logic                    led;
        logic [DW-1:0]           rdata;
    } st_t;

    localparam st_t ST_RST = '{cfg: CFG_RST, default: '0};

    st_t  st_q;
    st_t  st_d;
    s32_t e;
    s32_t ae;
    s32_t dterm;
    s32_t alpha;
    s32_t fbv;
    logic compute;
    logic freeze;

    function automatic s32_t u32(input logic [DW-1:0] x);
        u32 = $signed({16'h0000, x});
    endfunction : u32

    function automatic s32_t sat(input s32_t x, input s32_t lo, input s32_t hi);
        sat = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction : sat

    function automatic s32_t lerp(input logic [DW-1:0] a, input logic [DW-1:0] b, input s32_t w);
        lerp = u32(a) + ((u32(b) - u32(a)) * w) / ALPHA_ONE;
    endfunction : lerp

    // first order filter in 8 fractional bits, zero time passes straight through
    function automatic s32_t filt(input s32_t y, input s32_t x, input logic [DW-1:0] t);
        filt = y + ((x <<< 8) - y) / (u32(t) * B_PER_10MS + 1);
    endfunction : filt

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s32_t kp;
        s32_t ti;
        s32_t td;
        s32_t p;
        s32_t u;
        s32_t step;
        s32_t rt;
        s32_t rev;
        s32_t sp_n;
        logic lvl;
        logic [DW-1:0] ctl;
        kp = '0;
        ti = '0;
        td = '0;
        p = '0;
        u = '0;
        step = '0;
        rt = '0;
        sp_n = '0;
        lvl = 1'b0;
        st_d = st_q;
        ctl = st_q.cfg[A_CTRL];
        rev = u32(st_q.cfg[A_REVCUT]);
        compute = i_running | ctl[F_STOPC];
        // free-running beat divider
        st_d.beat = (st_q.beat_cnt == 32'(BEAT_CYCLES - 1));
        st_d.beat_cnt = st_d.beat ? '0 : st_q.beat_cnt + 32'h1;
        st_d.run_prev = i_running;
        fbv = st_q.fb_f >>> 8;
        e = st_q.sp - fbv;
        if (ctl[F_DIR]) begin
            e = -e;
        end
        ae = (e < 0) ? -e : e;
        // gain set blend, 0 = set one, ALPHA_ONE = set two
        case (ctl[F_SW +: 2])
            2'h1: alpha = i_gain_sel ? ALPHA_ONE : 0;
            2'h2: begin
                if (ae <= u32(st_q.cfg[A_SWLO])) begin
                    alpha = 0;
                end else if (ae >= u32(st_q.cfg[A_SWHI])) begin
                    alpha = ALPHA_ONE;
                end else begin
                    alpha = ((ae - u32(st_q.cfg[A_SWLO])) * ALPHA_ONE)
                          / (u32(st_q.cfg[A_SWHI]) - u32(st_q.cfg[A_SWLO]));
                end
            end
            2'h3: alpha = (sat(u32(i_abs_freq), 0, FULL) * ALPHA_ONE) / FULL;
            default: alpha = 0;
        endcase
        kp = lerp(st_q.cfg[A_KP1], st_q.cfg[A_KP2], alpha);
        ti = sat(lerp(st_q.cfg[A_TI1], st_q.cfg[A_TI2], alpha), 1, FULL);
        td = lerp(st_q.cfg[A_TD1], st_q.cfg[A_TD2], alpha);
        p = (kp * e) / KP_DIV;
        // full swing within td gives full output
        dterm = ((fbv - st_q.fb_prev) * td) / TD_MS_PER_BEAT;
        if (!ctl[F_DIR]) begin
            dterm = -dterm;
        end
        dterm = sat(dterm, -u32(st_q.cfg[A_DCLIP]), u32(st_q.cfg[A_DCLIP]));
        freeze = (ctl[F_ISEP] & i_int_pause) | (ctl[F_ILIM] & i_at_limit);
        ////////////////////////////////////////////////////////////////////
        if (st_q.beat && compute) begin
            st_d.fb_f = filt(st_q.fb_f, u32(i_feedback), st_q.cfg[A_FBFILT]);
            st_d.fb_prev = fbv;
            rt = u32(st_q.cfg[A_RAMP]) * B_PER_10MS;
            step = (rt == 0) ? FULL : sat(FULL / ((rt == 0) ? 1 : rt), 1, FULL);
            sp_n = st_q.sp + sat(u32(i_setpoint) - st_q.sp, -step, step);
            st_d.sp = sp_n;
            if (!freeze) begin
                st_d.iacc = sat(st_q.iacc + (e <<< 8) / (ti * B_PER_10MS),
                                -(FULL <<< 8), FULL <<< 8);
            end
            u = sat(p + (st_d.iacc >>> 8) + dterm, -rev, FULL);
            if (ae < u32(st_q.cfg[A_DBAND])) begin
                u = st_q.raw;
                st_d.iacc = st_q.iacc;
            end
            if (st_q.asleep) begin
                u = 0;
                st_d.iacc = '0;
            end
            // increase and decrease limited separately
            u = sat(u, st_q.raw - u32(st_q.cfg[A_RSTEP]),
                    st_q.raw + u32(st_q.cfg[A_FSTEP]));
            st_d.raw = u;
            st_d.out_f = filt(st_q.out_f, u, st_q.cfg[A_OUTFILT]);
            st_d.cmd = DW'(sat(st_d.out_f >>> 8, -rev, FULL));
        end
        ////////////////////////////////////////////////////////////////////
        // initial value hold after start, bumpless hand-over via integral
        if (i_running && !st_q.run_prev) begin
            st_d.holding = 1'b1;
            st_d.hold_cnt = 32'(u32(st_q.cfg[A_HOLD]) * B_PER_10MS);
        end else if (st_q.holding && st_q.beat) begin
            if (st_q.hold_cnt == '0) begin
                st_d.holding = 1'b0;
            end else begin
                st_d.hold_cnt = st_q.hold_cnt - 32'h1;
            end
        end
        if (st_d.holding) begin
            st_d.raw = sat(u32(st_q.cfg[A_INIT]), -rev, FULL);
            st_d.out_f = st_d.raw <<< 8;
            st_d.iacc = st_d.raw <<< 8;
            st_d.cmd = DW'(st_d.raw);
        end
        ////////////////////////////////////////////////////////////////////
        // feedback loss, counted in beats while running
        if (st_q.beat) begin
            // zero threshold switches detection off
            if (st_q.cfg[A_LOSSTHR] != '0 && i_running && fbv < u32(st_q.cfg[A_LOSSTHR])) begin
                st_d.loss_cnt = st_q.loss_cnt + 32'h1;
                if (st_q.loss_cnt >= 32'(u32(st_q.cfg[A_LOSSTIME]) * B_PER_100MS)) begin
                    st_d.fault = 1'b1;
                end
            end else begin
                st_d.loss_cnt = '0;
            end
        end
        ////////////////////////////////////////////////////////////////////
        // pressure sleep and wake, levels relative to setpoint
        if (!ctl[F_SLEEP] || !i_running) begin
            st_d.asleep = 1'b0;
            st_d.slp_cnt = '0;
        end else if (st_q.beat) begin
            if (st_q.asleep) begin
                lvl = fbv * PCT_DIV < u32(st_q.cfg[A_WAKEPCT]) * st_q.sp;
                rt = u32(st_q.cfg[A_WAKEDLY]) * B_PER_100MS;
            end else begin
                lvl = fbv * PCT_DIV > u32(st_q.cfg[A_SLPPCT]) * st_q.sp;
                rt = u32(st_q.cfg[A_SLPDLY]) * B_PER_100MS;
            end
            // counters compared at full width, the helper only takes register words
            if (!lvl) begin
                st_d.slp_cnt = '0;
            end else if (st_q.slp_cnt >= 32'(rt)) begin
                st_d.asleep = !st_q.asleep;
                st_d.slp_cnt = '0;
            end else begin
                st_d.slp_cnt = st_q.slp_cnt + 32'h1;
            end
        end
        // indicator blink, restarts lit on every sleep entry
        if (!st_q.asleep) begin
            st_d.blink = 1'b1;
            st_d.blink_cnt = '0;
        end else if (st_q.beat) begin
            if (st_q.blink_cnt == 16'(BLINK_BEATS - 1)) begin
                st_d.blink_cnt = '0;
                st_d.blink = !st_q.blink;
            end else begin
                st_d.blink_cnt = st_q.blink_cnt + 16'h1;
            end
        end
        st_d.led = i_running & st_q.blink;
        ////////////////////////////////////////////////////////////////////
        // register port; a fault in the clearing cycle survives
        if (i_wr && i_addr < AW'(NCFG)) begin
            st_d.cfg[i_addr] = i_wdata;
        end
        if (i_wr && i_addr == A_STATUS && i_wdata[F_FAULT] && !(st_d.fault && !st_q.fault)) begin
            st_d.fault = 1'b0;
        end
        st_d.rdata = '0;
        if (i_rd) begin
            if (i_addr < AW'(NCFG)) begin
                st_d.rdata = st_q.cfg[i_addr];
            end else if (i_addr == A_STATUS) begin
                st_d.rdata = {13'h0000, st_q.holding, st_q.asleep, st_q.fault};
            end else if (i_addr == A_OUT) begin
                st_d.rdata = st_q.cmd;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_freq_cmd = st_q.cmd;
    assign o_beat = st_q.beat;
    assign o_loss_fault = st_q.fault;
    assign o_asleep = st_q.asleep;
    assign o_run_led = st_q.led;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    property p_rev_clamp;
        $signed(st_q.cmd) >= -u32(st_q.cfg[A_REVCUT]);
    endproperty
    a_rev_clamp: assert property (p_rev_clamp) else $error("reverse output beyond cutoff");

    property p_deadband;
        (st_q.beat && compute && !st_q.asleep && !st_d.holding && ae < u32(st_q.cfg[A_DBAND]))
            |=> (st_q.raw == $past(st_q.raw));
    endproperty
    a_deadband: assert property (p_deadband) else $error("output moved inside deadband");

    property p_dclip;
        (dterm <= u32(st_q.cfg[A_DCLIP])) && (dterm >= -u32(st_q.cfg[A_DCLIP]));
    endproperty
    a_dclip: assert property (p_dclip) else $error("derivative exceeds clip");

    property p_cond0;
        (st_q.cfg[A_CTRL][F_SW +: 2] == 2'h0) |-> (alpha == 0);
    endproperty
    a_cond0: assert property (p_cond0) else $error("gain set two used in condition zero");

    property p_cond1;
        (st_q.cfg[A_CTRL][F_SW +: 2] == 2'h1) |-> (alpha == (i_gain_sel ? ALPHA_ONE : 0));
    endproperty
    a_cond1: assert property (p_cond1) else $error("terminal gain select ignored");

    property p_slew;
        (st_q.beat && !st_d.holding && !st_q.holding) |=>
            ((st_q.raw - $past(st_q.raw)) <= u32(st_q.cfg[A_FSTEP]))
            && (($past(st_q.raw) - st_q.raw) <= u32(st_q.cfg[A_RSTEP]));
    endproperty
    a_slew: assert property (p_slew) else $error("per-beat step limit exceeded");

    property p_hold;
        st_q.holding |-> ($signed(st_q.cmd) == sat(u32(st_q.cfg[A_INIT]), -u32(st_q.cfg[A_REVCUT]), FULL));
    endproperty
    a_hold: assert property (p_hold) else $error("output not at initial value in hold");

    property p_freeze;
        (st_q.beat && freeze && !st_q.asleep && !st_d.holding) |=> (st_q.iacc == $past(st_q.iacc));
    endproperty
    a_freeze: assert property (p_freeze) else $error("integral moved while frozen");

    property p_fault_cause;
        $rose(st_q.fault) |-> ($past(st_q.cfg[A_LOSSTHR]) != '0);
    endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("loss fault with zero threshold");

    property p_sleep_basis;
        (!st_q.cfg[A_CTRL][F_SLEEP]) |=> !st_q.asleep;
    endproperty
    a_sleep_basis: assert property (p_sleep_basis) else $error("pressure sleep without basis");

    property p_beat_gap;
        st_q.beat |=> !st_q.beat [*2];
    endproperty
    a_beat_gap: assert property (p_beat_gap) else $error("beat pulses too close");

    // these look at registered state, so a wrong decode upstream trips them; p_stop_hold and p_sleep_zero reuse the compute decode
    property p_stop_hold;
        (st_q.beat && !compute && !st_q.holding) |=> (st_q.cmd == $past(st_q.cmd));
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("command moved while stopped");

    property p_loss_off;
        (st_q.cfg[A_LOSSTHR] == '0 && !st_q.fault) |=> !st_q.fault;
    endproperty
    a_loss_off: assert property (p_loss_off) else $error("loss fault raised with detection off");

    property p_fault_sticky;
        (st_q.fault && !(i_wr && i_addr == A_STATUS && i_wdata[F_FAULT])) |=> st_q.fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("loss fault dropped without clear");

    property p_hold_start;
        (i_running && !st_q.run_prev) |=> st_q.holding;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("no initial hold after start");

    property p_sleep_zero;
        (st_q.beat && compute && st_q.asleep && !st_d.holding && st_q.raw == 0) |=> (st_q.raw == 0);
    endproperty
    a_sleep_zero: assert property (p_sleep_zero) else $error("output left zero while asleep");

    c_sleep: cover property ($rose(st_q.asleep));
    c_wake: cover property ($fell(st_q.asleep) && i_running);
    c_fault: cover property ($rose(st_q.fault));
    c_hold_end: cover property ($fell(st_q.holding));
    c_deadband: cover property (st_q.beat && compute && ae < u32(st_q.cfg[A_DBAND]));
endmodule : process_pid_regulator
`default_nettype wire

/* tb/drive_side_model.sv */
`default_nettype none
module drive_side_model (
    input  wire logic signed [15:0] i_cmd,
    input  wire logic [15:0]        i_fb_set,
    input  wire logic               i_sel_set,
    input  wire logic               i_pause_set,
    output logic [15:0]             o_feedback,
    output logic [15:0]             o_abs_freq,
    output logic                    o_at_limit,
    output logic                    o_gain_sel,
    output logic                    o_int_pause
);
    timeunit 1ns;
    timeprecision 100ps;
    // sensor is ideal: no lag, so expectations stay exact
    assign o_feedback  = i_fb_set;
    // frequency stage reports magnitude of the command
    assign o_abs_freq  = i_cmd[15] ? 16'(-i_cmd) : 16'(i_cmd);
    assign o_at_limit  = (i_cmd >= 16'sh2710) || (i_cmd <= 16'sh0000);
    // terminals follow the bench's switch settings
    assign o_gain_sel  = i_sel_set;
    assign o_int_pause = i_pause_set;
endmodule : drive_side_model
`default_nettype wire

/* tb/tb_process_pid_regulator.sv */
`default_nettype none
module tb_process_pid_regulator;
    timeunit 1ns;
    timeprecision 100ps;
    import pid_reg_pkg::*;
    localparam int BC = 20;
    logic               i_mclk = 1'b0;
    logic               i_rstn = 1'b0;
    logic [AW-1:0]      i_addr = 5'h00;
    logic [DW-1:0]      i_wdata = 16'h0000;
    logic               i_wr = 1'b0;
    logic               i_rd = 1'b0;
    logic [DW-1:0]      i_setpoint = 16'h2710;
    logic               i_running = 1'b0;
    logic [15:0]        fb_set = 16'h0000;
    logic               sel = 1'b0;
    logic               pause = 1'b0;
    logic [DW-1:0]      o_rdata, i_feedback, i_abs_freq;
    logic               i_gain_sel, i_int_pause, i_at_limit;
    logic signed [DW-1:0] o_freq_cmd;
    logic               o_beat, o_loss_fault, o_asleep, o_run_led;
    int                 miscompares = 0;
    int                 n_compared = 0;

    process_pid_regulator #(.BEAT_CYCLES(BC)) uut (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_setpoint, .i_feedback, .i_abs_freq, .i_running, .i_gain_sel, .i_int_pause,
        .i_at_limit, .o_freq_cmd, .o_beat, .o_loss_fault, .o_asleep, .o_run_led);
    drive_side_model far (.i_cmd(o_freq_cmd), .i_fb_set(fb_set), .o_feedback(i_feedback),
        .i_sel_set(sel), .i_pause_set(pause), .o_abs_freq(i_abs_freq), .o_at_limit(i_at_limit),
        .o_gain_sel(i_gain_sel), .o_int_pause(i_int_pause));

    always #2 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    // waits for n beat pulses, then for the command update behind each
    task automatic beats(input int n);
        int k;
        for (int b = 0; b < n; b++) begin
            k = 0;
            do begin
                @(posedge i_mclk);
                #1 k++;
            end while (o_beat !== 1'b1 && k < 2 * BC);
            if (k >= 2 * BC) begin
                miscompares++;
                conclude();
            end
            @(posedge i_mclk); #1;
        end
    endtask : beats

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [15:0] d;
        rd(A_DCLIP, d);
        chk(d, 16'h000A);
        rd(A_REVCUT, d);
        chk(d, 16'h0000);
        rd(A_SWLO, d);
        chk(d, 16'h07D0);
        rd(A_SWHI, d);
        chk(d, 16'h1F40);
        rd(A_WAKEPCT, d);
        chk(d, 16'h0320);
        rd(5'h1F, d);
        chk(d, 16'h0000);
        wr(A_KP1, 16'h03E8);
        rd(A_KP1, d);
        chk(d, 16'h03E8);
    endtask : t_regs

    task automatic t_hold_step();
        logic [15:0] d, c;
        wr(A_INIT, 16'h0BB8);
        wr(A_HOLD, 16'h0002);
        wr(A_FSTEP, 16'h0032);
        @(posedge i_mclk);
        i_running <= 1'b1;
        @(posedge i_mclk);
        #1 chk(o_freq_cmd, 16'h0BB8);
        beats(8);
        chk(o_freq_cmd, 16'h0BB8);
        rd(A_STATUS, d); chk(d & 16'h0004, 16'h0004);
        beats(4);
        rd(A_STATUS, d); chk(d & 16'h0004, 16'h0000);
        // large error: only the step limit governs the climb
        for (int i = 0; i < 2; i++) begin
            c = o_freq_cmd;
            beats(1);
            chk(o_freq_cmd, c + 16'h0032);
        end
    endtask : t_hold_step

    task automatic t_reverse();
        wr(A_RSTEP, 16'h2710);
        wr(A_CTRL, 16'h0001);
        beats(3);
        chk(o_freq_cmd, 16'h0000);
        wr(A_REVCUT, 16'h00C8);
        beats(3);
        chk(o_freq_cmd, 16'hFF38);
    endtask : t_reverse

    task automatic t_loss();
        wr(A_LOSSTHR, 16'h03E8);
        wr(A_LOSSTIME, 16'h0001);
        beats(45);
        chk({15'h0000, o_loss_fault}, 16'h0000);
        beats(10);
        chk({15'h0000, o_loss_fault}, 16'h0001);
        @(posedge i_mclk);
        fb_set <= 16'h1388;
        wr(A_STATUS, 16'h0001);
        @(posedge i_mclk);
        #1 chk({15'h0000, o_loss_fault}, 16'h0000);
    endtask : t_loss

    task automatic t_sleep();
        logic l;
        int   k;
        @(posedge i_mclk);
        i_setpoint <= 16'h1388;
        wr(A_SLPDLY, 16'h0000);
        wr(A_CTRL, 16'h0004);
        fb_set <= 16'h1770;
        beats(3);
        chk({15'h0000, o_asleep}, 16'h0001);
        // the step limit still governs the last climb back to zero
        beats(1);
        chk(o_freq_cmd, 16'h0000);
        // find a blink edge, then time one half period of 250 beats
        l = o_run_led;
        k = 0;
        while (o_run_led === l && k < 260) begin
            beats(1);
            k++;
        end
        if (k >= 260) begin
            miscompares++;
            conclude();
        end
        l = o_run_led;
        beats(249);
        chk({15'h0000, o_run_led}, {15'h0000, l});
        beats(2);
        chk({15'h0000, o_run_led}, {15'h0000, ~l});
        wr(A_WAKEDLY, 16'h0001);
        fb_set <= 16'h03E8;
        beats(45);
        chk({15'h0000, o_asleep}, 16'h0001);
        beats(10);
        chk({15'h0000, o_asleep}, 16'h0000);
    endtask : t_sleep

    task automatic t_stop();
        logic [15:0] c;
        wr(A_CTRL, 16'h0000);
        @(posedge i_mclk);
        i_running <= 1'b0;
        beats(1);
        c = o_freq_cmd;
        beats(3);
        chk(o_freq_cmd, c);
        wr(A_CTRL, 16'h0002);
        beats(3);
        chk(o_freq_cmd, c + 16'h0096);
        wr(A_DBAND, 16'h1388);
        beats(2);
        chk(o_freq_cmd, c + 16'h0096);
        // proportional off: only the integral moves the output
        wr(A_KP1, 16'h0000);
        wr(A_DBAND, 16'h0000);
        pause <= 1'b1;
        wr(A_CTRL, 16'h0102);
        beats(2);
        c = o_freq_cmd;
        beats(2);
        chk(o_freq_cmd, c);
        @(posedge i_mclk);
        pause <= 1'b0;
        beats(3);
        chk(o_freq_cmd, c + 16'h000C);
        c = o_freq_cmd;
        wr(A_CTRL, 16'h0012);
        sel <= 1'b1;
        beats(1);
        chk(o_freq_cmd, c + 16'h0032);
    endtask : t_stop

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_regs();
        t_hold_step();
        t_reverse();
        t_loss();
        t_sleep();
        t_stop();
        conclude();
    end

    // a hang counts as a mismatch
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
endmodule : tb_process_pid_regulator
`default_nettype wire
